//--- hart_debug_state_control.sv
`timescale 1ns/100ps

// What this block does
// - running and halted are reported on two separate status outputs
// - neither running nor halted asserted means the hart is unavailable
// - unavailable from reset until fetch permission is seen high after release
// - afterwards halted while in debug mode, running otherwise
// - exactly one of reset-seen, running, halted is high every cycle
// - halt request before fetch permission goes straight to halted
// - a later halt request may show running briefly before halting
// - halt request while running reaches halted in the next cycle
// - breakpoint outside debug with bit clear traps and updates trap pc and cause, except as a stepped handler's first instruction
// - no trap value register exists, the instruction word is not kept
// - breakpoint outside debug with bit set enters debug, updates debug pc and cause
// - the break-to-halt bit resets to zero
// - debug control/status is reachable only while in debug mode
// - breakpoint inside debug restarts at the halt vector, no register changes
// - interrupt during a step retires the handler's first instruction then halts
// - the decoding instruction when halt request rises is not executed
// - a fault in debug mode jumps to the word-aligned debug fault vector
module hart_debug_state_control (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clock_enable,
  // register port
  input wire hart_debug_pkg::bus_req_type bus_req,
  output logic [31:0] bus_rdata,
  // debug module side
  input wire logic halt_request_in,
  input wire logic [31:0] halt_entry_vector,
  input wire logic [31:0] debug_fault_vector,
  input wire logic fetch_permit_in,
  output hart_debug_pkg::debug_flags_type debug_flags,
  // pipeline side
  input wire hart_debug_pkg::decode_type decode_in,
  input wire hart_debug_pkg::trap_req_type exception_in,
  input wire hart_debug_pkg::trap_req_type irq_take_in,
  input wire logic resume_in,
  output hart_debug_pkg::redirect_type redirect,
  output logic decode_kill,
  // interrupt
  output logic irq
);

  // ==========================================================
  // state
  typedef struct packed {
    hart_debug_pkg::debug_fsm_type fsm;
    logic [hart_debug_pkg::sync_stages-1:0] sync;
    logic fetch_level;
    logic halt_seen;
    logic break_to_halt;
    logic step;
    logic [2:0] cause;
    logic [31:0] dpc;
    logic [31:0] mtvec;
    logic [31:0] mepc;
    logic [31:0] mcause;
    logic [hart_debug_pkg::event_count-1:0] ev_status;
    logic [hart_debug_pkg::event_count-1:0] ev_mask;
    logic [31:0] rdata;
    hart_debug_pkg::debug_flags_type flags;
    hart_debug_pkg::redirect_type redirect;
    logic decode_kill;
    logic irq;
  } state_type;

  localparam state_type state_reset = '{
    fsm: hart_debug_pkg::fsm_unavailable,
    sync: '0,
    fetch_level: 1'b0,
    halt_seen: 1'b0,
    break_to_halt: hart_debug_pkg::break_to_halt_reset,
    step: 1'b0,
    cause: 3'h0,
    dpc: hart_debug_pkg::word_reset,
    mtvec: hart_debug_pkg::word_reset,
    mepc: hart_debug_pkg::word_reset,
    mcause: hart_debug_pkg::word_reset,
    ev_status: '0,
    ev_mask: hart_debug_pkg::mask_reset,
    rdata: hart_debug_pkg::word_reset,
    flags: '{reset_seen: 1'b1, running: 1'b0, halted: 1'b0},
    redirect: '{valid: 1'b0, pc: hart_debug_pkg::word_reset},
    decode_kill: 1'b0,
    irq: 1'b0
  };

  state_type state_q;
  state_type state_d;

  function automatic logic [31:0] word_align(input logic [31:0] a);
    return {a[31:2], 2'b00};
  endfunction

  function automatic logic [31:0] dcsr_word(input state_type s);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[hart_debug_pkg::break_to_halt_pos] = s.break_to_halt;
    w[hart_debug_pkg::cause_lsb +: 3] = s.cause;
    w[hart_debug_pkg::step_pos] = s.step;
    return w;
  endfunction

  // ==========================================================
  // next state
  always_comb begin
    state_type n;
    logic enter;
    logic [2:0] enter_cause;
    logic [31:0] enter_pc;
    logic trap;
    logic [31:0] trap_cause;
    logic [hart_debug_pkg::event_count-1:0] ev;
    logic [hart_debug_pkg::event_count-1:0] clr;
    logic in_debug;
    n = state_q;
    enter = 1'b0;
    enter_cause = 3'h0;
    enter_pc = 32'h0000_0000;
    trap = 1'b0;
    trap_cause = 32'h0000_0000;
    ev = '0;
    clr = '0;
    in_debug = (state_q.fsm == hart_debug_pkg::fsm_halted);
    n.redirect.valid = 1'b0;
    n.decode_kill = 1'b0;
    n.rdata = 32'h0000_0000;
    // fetch permission is a pin: three flops, a change counts once the last two agree
    n.sync = {state_q.sync[hart_debug_pkg::sync_stages-2:0], fetch_permit_in};
    if (state_q.sync[2] == state_q.sync[1]) begin
      n.fetch_level = state_q.sync[2];
    end
    // register writes
    if (bus_req.write) begin
      if (bus_req.addr == hart_debug_pkg::dcsr_offset) begin
        if (in_debug) begin
          n.break_to_halt = bus_req.wdata[hart_debug_pkg::break_to_halt_pos];
          n.step = bus_req.wdata[hart_debug_pkg::step_pos];
        end else begin
          ev[hart_debug_pkg::ev_illegal_access] = 1'b1;
        end
      end else if (bus_req.addr == hart_debug_pkg::dpc_offset) begin
        if (in_debug) begin
          n.dpc = bus_req.wdata;
        end else begin
          ev[hart_debug_pkg::ev_illegal_access] = 1'b1;
        end
      end else if (bus_req.addr == hart_debug_pkg::trap_vector_offset) begin
        n.mtvec = word_align(bus_req.wdata);
      end else if (bus_req.addr == hart_debug_pkg::trap_return_pc_offset) begin
        n.mepc = bus_req.wdata;
      end else if (bus_req.addr == hart_debug_pkg::trap_cause_offset) begin
        n.mcause = bus_req.wdata;
      end else if (bus_req.addr == hart_debug_pkg::event_status_offset) begin
        clr = bus_req.wdata[hart_debug_pkg::event_count-1:0];
      end else if (bus_req.addr == hart_debug_pkg::event_mask_offset) begin
        n.ev_mask = bus_req.wdata[hart_debug_pkg::event_count-1:0];
      end
    end
    // register reads, data in the following cycle; unmapped reads as zero
    if (bus_req.read) begin
      if (bus_req.addr == hart_debug_pkg::dcsr_offset) begin
        if (in_debug) begin
          n.rdata = dcsr_word(state_q);
        end else begin
          ev[hart_debug_pkg::ev_illegal_access] = 1'b1;
        end
      end else if (bus_req.addr == hart_debug_pkg::dpc_offset) begin
        if (in_debug) begin
          n.rdata = state_q.dpc;
        end else begin
          ev[hart_debug_pkg::ev_illegal_access] = 1'b1;
        end
      end else if (bus_req.addr == hart_debug_pkg::trap_vector_offset) begin
        n.rdata = state_q.mtvec;
      end else if (bus_req.addr == hart_debug_pkg::trap_return_pc_offset) begin
        n.rdata = state_q.mepc;
      end else if (bus_req.addr == hart_debug_pkg::trap_cause_offset) begin
        n.rdata = state_q.mcause;
      end else if (bus_req.addr == hart_debug_pkg::state_offset) begin
        n.rdata = {28'h000_0000, state_q.fetch_level, state_q.flags};
      end else if (bus_req.addr == hart_debug_pkg::event_status_offset) begin
        n.rdata = {28'h000_0000, state_q.ev_status};
      end else if (bus_req.addr == hart_debug_pkg::event_mask_offset) begin
        n.rdata = {28'h000_0000, state_q.ev_mask};
      end
    end
    // run control
    case (state_q.fsm)
      hart_debug_pkg::fsm_unavailable: begin
        // a request seen before fetch is allowed is kept so no running cycle shows
        if (halt_request_in) begin
          n.halt_seen = 1'b1;
        end
        if (state_q.fetch_level) begin
          if (state_q.halt_seen || halt_request_in) begin
            enter = 1'b1;
            enter_cause = hart_debug_pkg::cause_halt_request;
            enter_pc = decode_in.pc;
          end else begin
            n.fsm = hart_debug_pkg::fsm_running;
          end
          n.halt_seen = 1'b0;
        end
      end
      hart_debug_pkg::fsm_running: begin
        if (halt_request_in) begin
          n.decode_kill = 1'b1;
          enter = 1'b1;
          enter_cause = hart_debug_pkg::cause_halt_request;
          enter_pc = decode_in.pc;
        end else if (decode_in.valid && decode_in.is_break) begin
          if (state_q.break_to_halt) begin
            enter = 1'b1;
            enter_cause = hart_debug_pkg::cause_ebreak;
            enter_pc = decode_in.pc;
          end else begin
            trap = 1'b1;
            trap_cause = hart_debug_pkg::breakpoint_cause;
            ev[hart_debug_pkg::ev_break_trap] = 1'b1;
          end
        end else if (exception_in.valid) begin
          trap = 1'b1;
          trap_cause = exception_in.cause;
        end else if (irq_take_in.valid) begin
          trap = 1'b1;
          trap_cause = irq_take_in.cause;
          if (state_q.step) begin
            n.fsm = hart_debug_pkg::fsm_step_irq;
          end
        end else if (decode_in.valid && state_q.step) begin
          enter = 1'b1;
          enter_cause = hart_debug_pkg::cause_step;
          enter_pc = decode_in.next_pc;
        end
      end
      hart_debug_pkg::fsm_step_irq: begin
        // the step halt waits until the handler's first instruction has retired
        if (halt_request_in) begin
          n.decode_kill = 1'b1;
          enter = 1'b1;
          enter_cause = hart_debug_pkg::cause_halt_request;
          enter_pc = decode_in.pc;
        end else if (decode_in.valid) begin
          enter = 1'b1;
          enter_cause = hart_debug_pkg::cause_step;
          enter_pc = decode_in.next_pc;
          // a breakpoint as the handler's first instruction wins over the step when the break-to-halt bit is set
          if (decode_in.is_break && state_q.break_to_halt) begin
            enter_cause = hart_debug_pkg::cause_ebreak;
            enter_pc = decode_in.pc;
          end
        end
      end
      hart_debug_pkg::fsm_halted: begin
        if (decode_in.valid && decode_in.is_break) begin
          n.redirect.valid = 1'b1;
          n.redirect.pc = word_align(halt_entry_vector);
        end else if (exception_in.valid) begin
          n.redirect.valid = 1'b1;
          n.redirect.pc = word_align(debug_fault_vector);
          ev[hart_debug_pkg::ev_debug_fault] = 1'b1;
        end else if (resume_in) begin
          n.redirect.valid = 1'b1;
          n.redirect.pc = state_q.dpc;
          n.fsm = hart_debug_pkg::fsm_running;
        end
      end
      default: n.fsm = hart_debug_pkg::fsm_unavailable;
    endcase
    if (enter) begin
      n.fsm = hart_debug_pkg::fsm_halted;
      n.dpc = enter_pc;
      n.cause = enter_cause;
      n.redirect.valid = 1'b1;
      n.redirect.pc = word_align(halt_entry_vector);
      ev[hart_debug_pkg::ev_debug_entry] = 1'b1;
    end
    // only return pc and cause change; no instruction word is captured
    if (trap) begin
      n.mepc = decode_in.pc;
      n.mcause = trap_cause;
      n.redirect.valid = 1'b1;
      n.redirect.pc = state_q.mtvec;
    end
    // new events win over a clear in the same cycle
    n.ev_status = (state_q.ev_status & ~clr) | ev;
    n.irq = |(n.ev_status & n.ev_mask);
    n.flags.reset_seen = (n.fsm == hart_debug_pkg::fsm_unavailable);
    n.flags.running = (n.fsm == hart_debug_pkg::fsm_running) ||
                      (n.fsm == hart_debug_pkg::fsm_step_irq);
    n.flags.halted = (n.fsm == hart_debug_pkg::fsm_halted);
    state_d = n;
  end

  // ==========================================================
  // registers
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= state_reset;
    end else if (clock_enable) begin
      state_q <= state_d;
    end
  end

  assign debug_flags = state_q.flags;
  assign redirect = state_q.redirect;
  assign decode_kill = state_q.decode_kill;
  assign irq = state_q.irq;
  assign bus_rdata = state_q.rdata;

  // ==========================================================
  // checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  a_flags_one_hot: assert property (
    $onehot({debug_flags.reset_seen, debug_flags.running, debug_flags.halted}))
    else $error("status flags not one-hot");
  a_unavail_needs_fetch: assert property (
    debug_flags.reset_seen && !state_q.fetch_level |=> debug_flags.reset_seen)
    else $error("left unavailable without fetch permission");
  a_early_halt_direct: assert property (
    clock_enable && debug_flags.reset_seen && state_q.fetch_level &&
    (state_q.halt_seen || halt_request_in) |=> debug_flags.halted)
    else $error("early halt request passed through running");
  a_halt_from_run: assert property (
    clock_enable && debug_flags.running && halt_request_in |=>
    debug_flags.halted && decode_kill &&
    redirect.pc == {$past(halt_entry_vector[31:2]), 2'b00})
    else $error("halt request not honoured in one cycle");
  a_break_trap: assert property (
    clock_enable && state_q.fsm == hart_debug_pkg::fsm_running && !halt_request_in &&
    decode_in.valid && decode_in.is_break && !state_q.break_to_halt |=>
    debug_flags.running && redirect.valid && redirect.pc == $past(state_q.mtvec) &&
    state_q.mcause == hart_debug_pkg::breakpoint_cause)
    else $error("breakpoint trap misrouted");
  a_break_enter: assert property (
    clock_enable && debug_flags.running && !halt_request_in && decode_in.valid &&
    decode_in.is_break && state_q.break_to_halt |=>
    debug_flags.halted && state_q.cause == hart_debug_pkg::cause_ebreak &&
    state_q.dpc == $past(decode_in.pc))
    else $error("breakpoint debug entry wrong");
  a_break_in_debug: assert property (
    clock_enable && debug_flags.halted && decode_in.valid && decode_in.is_break &&
    !bus_req.write |=> debug_flags.halted && $stable(state_q.dpc) &&
    $stable(state_q.mepc) && $stable(state_q.mcause) && $stable(state_q.cause))
    else $error("breakpoint in debug changed state");
  a_dcsr_guarded: assert property (
    clock_enable && !debug_flags.halted && bus_req.write &&
    bus_req.addr == hart_debug_pkg::dcsr_offset |=> $stable(state_q.break_to_halt))
    else $error("debug register written outside debug mode");
  a_debug_fault: assert property (
    clock_enable && debug_flags.halted && exception_in.valid &&
    !(decode_in.valid && decode_in.is_break) |=>
    redirect.valid && redirect.pc == {$past(debug_fault_vector[31:2]), 2'b00})
    else $error("debug fault vector not used");
  a_step_irq_wait: assert property (
    clock_enable && state_q.fsm == hart_debug_pkg::fsm_step_irq && !decode_in.valid &&
    !halt_request_in |=> debug_flags.running)
    else $error("step halted before handler instruction retired");

endmodule // hart_debug_state_control

//--- hart_debug_pkg.sv
package hart_debug_pkg;

  // ==========================================================
  // register offsets (byte addresses, one word each)
  localparam logic [7:0] dcsr_offset = 8'h00;
  localparam logic [7:0] dpc_offset = 8'h04;
  localparam logic [7:0] trap_vector_offset = 8'h08;
  localparam logic [7:0] trap_return_pc_offset = 8'h0C;
  localparam logic [7:0] trap_cause_offset = 8'h10;
  localparam logic [7:0] state_offset = 8'h14;
  localparam logic [7:0] event_status_offset = 8'h18;
  localparam logic [7:0] event_mask_offset = 8'h1C;

  // ==========================================================
  // debug control/status field positions
  localparam int step_pos = 2;
  localparam int cause_lsb = 6;
  localparam int break_to_halt_pos = 15;

  // debug entry causes
  localparam logic [2:0] cause_ebreak = 3'h1;
  localparam logic [2:0] cause_halt_request = 3'h3;
  localparam logic [2:0] cause_step = 3'h4;

  // trap cause written by a trapping breakpoint
  localparam logic [31:0] breakpoint_cause = 32'h0000_0003;

  // ==========================================================
  // event bits of the status and mask registers
  localparam int ev_debug_entry = 0;
  localparam int ev_break_trap = 1;
  localparam int ev_debug_fault = 2;
  localparam int ev_illegal_access = 3;
  localparam int event_count = 4;

  // reset values
  localparam logic break_to_halt_reset = 1'b0;
  localparam logic [31:0] word_reset = 32'h0000_0000;
  localparam logic [3:0] mask_reset = 4'h0;

  // input synchroniser depth
  localparam int sync_stages = 3;

  // ==========================================================
  typedef enum logic [1:0] {
    fsm_unavailable,
    fsm_running,
    fsm_step_irq,
    fsm_halted
  } debug_fsm_type;

  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] addr;
    logic [31:0] wdata;
  } bus_req_type;

  typedef struct packed {
    logic valid;
    logic is_break;
    logic [31:0] pc;
    logic [31:0] next_pc;
  } decode_type;

  typedef struct packed {
    logic valid;
    logic [31:0] cause;
  } trap_req_type;

  typedef struct packed {
    logic valid;
    logic [31:0] pc;
  } redirect_type;

  typedef struct packed {
    logic reset_seen;
    logic running;
    logic halted;
  } debug_flags_type;

endpackage

//--- debug_module_model.sv
`timescale 1ns/100ps

// ==========================================================
// far-side run-control model: halt requests and entry vectors
module debug_module_model #(
  parameter logic [31:0] halt_vector = 32'h0000_1a00,
  parameter logic [31:0] fault_vector = 32'h0000_1b00
) (
  // clock
  input wire logic clock,
  // toward the hart
  output logic halt_request_in,
  output logic [31:0] halt_entry_vector,
  output logic [31:0] debug_fault_vector,
  // from the hart
  input wire hart_debug_pkg::debug_flags_type debug_flags
);
  // both vectors driven straight from the parameters, no alignment applied; the defaults have low bits zero
  assign halt_entry_vector = halt_vector;
  assign debug_fault_vector = fault_vector;

  initial halt_request_in = 1'b0;

  // request stays up until halted is seen or 40 cycles have passed, then drops
  task automatic raise_halt(output logic ok);
    ok = 1'b0;
    @(posedge clock);
    halt_request_in <= 1'b1;
    for (int i = 0; i < 40 && !ok; i++) begin
      @(negedge clock);
      ok = (debug_flags.halted === 1'b1);
      @(posedge clock);
    end
    halt_request_in <= 1'b0;
  endtask
endmodule // debug_module_model

//--- hart_debug_state_control_test.sv
`timescale 1ns/100ps

module hart_debug_state_control_test;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic clock_enable = 1'b1;
  hart_debug_pkg::bus_req_type bus_req = '0;
  logic [31:0] bus_rdata;
  logic halt_request_in;
  logic [31:0] halt_entry_vector;
  logic [31:0] debug_fault_vector;
  logic fetch_permit_in = 1'b0;
  hart_debug_pkg::debug_flags_type debug_flags;
  hart_debug_pkg::decode_type decode_in = '0;
  hart_debug_pkg::trap_req_type exception_in = '0;
  hart_debug_pkg::trap_req_type irq_take_in = '0;
  logic resume_in = 1'b0;
  hart_debug_pkg::redirect_type redirect;
  logic decode_kill;
  logic irq;
  int mismatches = 0;
  int n_tests = 0;
  logic saw_run = 1'b0;

  always #5 clock = ~clock;

  hart_debug_state_control dut (
    .clock(clock), .sys_rst(sys_rst), .clock_enable(clock_enable),
    .bus_req(bus_req), .bus_rdata(bus_rdata),
    .halt_request_in(halt_request_in), .halt_entry_vector(halt_entry_vector),
    .debug_fault_vector(debug_fault_vector), .fetch_permit_in(fetch_permit_in),
    .debug_flags(debug_flags), .decode_in(decode_in), .exception_in(exception_in),
    .irq_take_in(irq_take_in), .resume_in(resume_in), .redirect(redirect),
    .decode_kill(decode_kill), .irq(irq)
  );

  debug_module_model dm (
    .clock(clock), .halt_request_in(halt_request_in),
    .halt_entry_vector(halt_entry_vector), .debug_fault_vector(debug_fault_vector),
    .debug_flags(debug_flags)
  );

  // ==========================================================
  // checking and access tasks
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    @(posedge clock);
    bus_req <= '{1'b0, 1'b1, addr, data};
    @(posedge clock);
    bus_req <= '0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] addr, output logic [31:0] data);
    @(posedge clock);
    bus_req <= '{1'b1, 1'b0, addr, 32'h0000_0000};
    @(posedge clock);
    bus_req <= '0;
    #1;
    data = bus_rdata;
  endtask

  task automatic rd_is(input logic [7:0] addr, input logic [31:0] exp);
    logic [31:0] v;
    rd(addr, v);
    check("read", v, exp);
  endtask

  task automatic decode_once(input logic [31:0] pc, input logic brk);
    @(posedge clock);
    decode_in <= '{1'b1, brk, pc, pc + 32'h0000_0004};
    @(posedge clock);
    decode_in <= '0;
    #1;
  endtask

  // kind 0 resume, 1 exception, 2 interrupt taken
  task automatic pulse(input int kind);
    @(posedge clock);
    if (kind == 0) resume_in <= 1'b1;
    else if (kind == 1) exception_in <= '{1'b1, 32'h0000_0002};
    else irq_take_in <= '{1'b1, 32'h8000_000b};
    @(posedge clock);
    resume_in <= 1'b0;
    exception_in <= '0;
    irq_take_in <= '0;
    #1;
  endtask

  always @(negedge clock) begin
    check("one_flag", 32'($onehot(debug_flags)), 32'h0000_0001);
    if (debug_flags.running === 1'b1) saw_run = 1'b1;
  end

  // ==========================================================
  // scenarios
  initial begin
    logic [31:0] v;
    logic ok;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    #1;
    check("reset_seen", 32'(debug_flags.reset_seen), 32'h0000_0001);
    rd_is(hart_debug_pkg::state_offset, 32'h0000_0004);
    saw_run = 1'b0;
    // halt asked for before fetch permission: no running on the way
    fork
      dm.raise_halt(ok);
      begin
        repeat (4) @(posedge clock);
        fetch_permit_in <= 1'b1;
        #1;
        check("held_off", 32'(debug_flags.reset_seen), 32'h0000_0001);
      end
    join
    check("early_halt", 32'(ok), 32'h0000_0001);
    check("no_running", 32'(saw_run), 32'h0000_0000);
    rd_is(hart_debug_pkg::state_offset, 32'h0000_0009);
    rd(hart_debug_pkg::dcsr_offset, v);
    check("break_bit", 32'(v[15]), 32'h0000_0000);
    check("cause", 32'(v[8:6]), 32'(hart_debug_pkg::cause_halt_request));
    wr(hart_debug_pkg::dpc_offset, 32'h0000_0100);
    wr(hart_debug_pkg::dcsr_offset, 32'h0000_8000);
    rd(hart_debug_pkg::dcsr_offset, v);
    check("break_bit", 32'(v[15]), 32'h0000_0001);
    pulse(0);
    check("running", 32'(debug_flags.running), 32'h0000_0001);
    check("resume_pc", redirect.pc, 32'h0000_0100);
    // debug registers refused while running, refusal raises an event
    rd_is(hart_debug_pkg::dcsr_offset, 32'h0000_0000);
    rd_is(hart_debug_pkg::event_status_offset, 32'h0000_0009);
    wr(hart_debug_pkg::event_status_offset, 32'h0000_000f);
    rd_is(hart_debug_pkg::event_status_offset, 32'h0000_0000);
    wr(hart_debug_pkg::event_mask_offset, 32'h0000_0008);
    rd_is(hart_debug_pkg::event_mask_offset, 32'h0000_0008);
    check("irq_masked", 32'(irq), 32'h0000_0000);
    rd_is(hart_debug_pkg::dcsr_offset, 32'h0000_0000);
    repeat (2) @(posedge clock);
    #1;
    check("irq_set", 32'(irq), 32'h0000_0001);
    wr(hart_debug_pkg::event_status_offset, 32'h0000_0008);
    repeat (2) @(posedge clock);
    #1;
    check("irq_clear", 32'(irq), 32'h0000_0000);
    // breakpoint with the halt bit set
    decode_once(32'h0000_0200, 1'b1);
    check("halted", 32'(debug_flags.halted), 32'h0000_0001);
    check("entry_pc", redirect.pc, halt_entry_vector);
    rd_is(hart_debug_pkg::dpc_offset, 32'h0000_0200);
    rd(hart_debug_pkg::dcsr_offset, v);
    check("cause", 32'(v[8:6]), 32'(hart_debug_pkg::cause_ebreak));
    // breakpoint inside debug restarts the debug code only
    decode_once(32'h0000_0300, 1'b1);
    check("restart_kick", 32'(redirect.valid), 32'h0000_0001);
    check("restart_pc", redirect.pc, halt_entry_vector);
    check("halted", 32'(debug_flags.halted), 32'h0000_0001);
    rd_is(hart_debug_pkg::dpc_offset, 32'h0000_0200);
    rd_is(hart_debug_pkg::trap_return_pc_offset, 32'h0000_0000);
    pulse(1);
    check("fault_pc", redirect.pc, debug_fault_vector);
    check("halted", 32'(debug_flags.halted), 32'h0000_0001);
    // halt bit cleared: breakpoint traps instead
    wr(hart_debug_pkg::dcsr_offset, 32'h0000_0000);
    wr(hart_debug_pkg::trap_vector_offset, 32'h0000_0400);
    pulse(0);
    decode_once(32'h0000_0204, 1'b1);
    check("trap_pc", redirect.pc, 32'h0000_0400);
    check("running", 32'(debug_flags.running), 32'h0000_0001);
    rd_is(hart_debug_pkg::trap_return_pc_offset, 32'h0000_0204);
    rd_is(hart_debug_pkg::trap_cause_offset, hart_debug_pkg::breakpoint_cause);
    rd_is(8'h20, 32'h0000_0000);
    // halt request meets an instruction in decode
    fork
      dm.raise_halt(ok);
      begin
        decode_once(32'h0000_0500, 1'b0);
        check("kill", 32'(decode_kill), 32'h0000_0001);
        check("halted", 32'(debug_flags.halted), 32'h0000_0001);
      end
    join
    check("halt_ok", 32'(ok), 32'h0000_0001);
    rd_is(hart_debug_pkg::dpc_offset, 32'h0000_0500);
    // single step interrupted: handler's first instruction retires first
    wr(hart_debug_pkg::dcsr_offset, 32'h0000_0004);
    pulse(0);
    pulse(2);
    check("handler_pc", redirect.pc, 32'h0000_0400);
    check("running", 32'(debug_flags.running), 32'h0000_0001);
    decode_once(32'h0000_0400, 1'b0);
    check("halted", 32'(debug_flags.halted), 32'h0000_0001);
    rd_is(hart_debug_pkg::dpc_offset, 32'h0000_0404);
    rd(hart_debug_pkg::dcsr_offset, v);
    check("cause", 32'(v[8:6]), 32'(hart_debug_pkg::cause_step));
    // clock enable low freezes the hart: a resume pulse is lost
    @(posedge clock);
    clock_enable <= 1'b0;
    pulse(0);
    check("frozen", 32'(debug_flags.halted), 32'h0000_0001);
    check("frozen_kick", 32'(redirect.valid), 32'h0000_0000);
    @(posedge clock);
    clock_enable <= 1'b1;
    // reset while halted: back to reset-seen, held off until fetch is filtered again
    @(posedge clock);
    sys_rst <= 1'b1;
    @(posedge clock);
    sys_rst <= 1'b0;
    #1;
    check("rerun_reset", 32'(debug_flags.reset_seen), 32'h0000_0001);
    rd_is(hart_debug_pkg::state_offset, 32'h0000_0004);
    tally_and_finish();
  end

  // the scenarios need well under a thousand cycles
  initial begin
    #100_000;
    mismatches++;
    tally_and_finish();
  end
endmodule // hart_debug_state_control_test
